//--- core/kbdsc_top.sv
// kbdsc_top: keyboard and display scanning controller
`timescale 1ns/10ps
// Summary of operation
// - eight scan lines carry a single rotating high bit
// - bank select toggles after each full pass, high for digits eight to fifteen
// - individual mode refreshes both display registers on ports in step with scan
// - gas mode: port A bit 3 is display reset, bit 2 display clock
// - gas mode recirculates 16, 18 or 20 six-bit characters on own timing
// - return lines held low for sensor, pulsed low scanning, floating encoded
// - shift key is active high and only used while scanning a keyboard
// - active-low interrupt asserted while a key character is buffered, or from a sensor change until a FIFO read
// - control input is control key scanning, character strobe when encoded
// - low level on reset input resets the device, except the FIFO and sensor memory contents
// - eight-entry character FIFO, reused as sensor memory in sensor mode
// - scanned keys are debounced with two-key rollover
// - modes: encoded 8-bit, 64 keys plus shift and control, 64 sensors
// - display registers serve as hex, alphanumeric or indicator arrays
// - read data driven only in the cycle that returns it
// - mode write: upper bits pick display mode, lower bits keyboard mode
// - reset selects scanned keyboard and sixteen-character gas display
// - eleven millisecond key bounce delay while scanning a keyboard
// - clear resets scan logic and fills display memory with blanks
module kbdsc_top #(
  parameter int P_SCAN_CYC = kbdsc_pkg::SCAN_LINE_CYC,
  parameter int P_DEB_CYC = kbdsc_pkg::DEBOUNCE_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [3:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  output logic [7:0] o_scan_lines,
  output logic o_row_bank_select,
  output logic [3:0] o_display_port_a,
  output logic [3:0] o_display_port_b,
  input wire logic [7:0] i_return_lines,
  output logic [7:0] o_return_lines,
  output logic [7:0] o_return_lines_oe,
  input wire logic i_shift_key,
  input wire logic i_ctrl_strobe,
  output logic o_int_n
);
  import kbdsc_pkg::*;

  localparam int SW = $clog2(P_SCAN_CYC);
  localparam int DW = $clog2(P_DEB_CYC);
  localparam int GW = $clog2(GAS_CHAR_CYC);

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  logic [9:0] sync1;
  logic [9:0] sync2;
  logic ctrl_q;
  logic [7:0] ret;
  logic shift;
  logic ctrl;

  // two flops on every pin input; only sync2 is read
  // asynchronous low reset
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 10'h000;
      sync2 <= 10'h000;
      ctrl_q <= 1'b0;
    end else begin
      sync1 <= {i_ctrl_strobe, i_shift_key, i_return_lines};
      sync2 <= sync1;
      ctrl_q <= sync2[9];
    end
  end
  assign ret = sync2[7:0];
  assign shift = sync2[8];
  assign ctrl = sync2[9];

  // ----------------------------------------
  // register strobes and mode
  // ----------------------------------------
  logic [1:0] disp_mode;
  logic [1:0] kbd_mode;
  logic clr_hit;
  logic data_hit;
  logic fifo_rd;

  assign clr_hit = i_wr && (i_addr == ADDR_CLEAR);
  assign data_hit = (i_wr || i_rd) && (i_addr == ADDR_DATA);
  assign fifo_rd = i_rd && (i_addr == ADDR_FIFO);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      disp_mode <= RST_DISP;
      kbd_mode <= RST_KBD;
    end else if (i_wr && (i_addr == ADDR_MODE)) begin
      disp_mode <= i_wdata[MODE_DISP_LSB +: 2];
      kbd_mode <= i_wdata[MODE_KBD_LSB +: 2];
    end
  end

  // ----------------------------------------
  // scan timing
  // ----------------------------------------
  logic [SW-1:0] scan_cnt;
  logic [2:0] line;
  logic bank;
  logic line_end;

  assign line_end = (scan_cnt == SW'(P_SCAN_CYC - 1));

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      scan_cnt <= '0;
      line <= 3'h0;
      bank <= 1'b0;
      o_scan_lines <= 8'h01;
    end else if (clr_hit) begin
      scan_cnt <= '0;
      line <= 3'h0;
      bank <= 1'b0;
      o_scan_lines <= 8'h01;
    end else if (line_end) begin
      scan_cnt <= '0;
      line <= line + 3'h1;
      o_scan_lines <= {o_scan_lines[6:0], o_scan_lines[7]};
      if (line == 3'h7) begin
        bank <= ~bank;
      end
    end else begin
      scan_cnt <= scan_cnt + SW'(1);
    end
  end
  assign o_row_bank_select = bank;

  // ----------------------------------------
  // display memory and pointer
  // ----------------------------------------
  logic [3:0] disp_a [DISP_DEPTH];
  logic [3:0] disp_b [DISP_DEPTH];
  logic [5:0] ptr;
  logic [4:0] pidx;

  assign pidx = ptr[5:1];

  // pointer alternates A and B, so any layout can be loaded
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ptr <= 6'h00;
    end else if (clr_hit) begin
      ptr <= 6'h00;
    end else if (i_wr && (i_addr == ADDR_PTR)) begin
      ptr <= (i_wdata[5:0] > PTR_LAST) ? 6'h00 : i_wdata[5:0];
    end else if (data_hit) begin
      ptr <= (ptr == PTR_LAST) ? 6'h00 : ptr + 6'h01;
    end
  end

  // clear fills blanks per display mode
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int i = 0; i < DISP_DEPTH; i++) begin
        disp_a[i] <= {2'b00, BLANK_GAS[5:4]};
        disp_b[i] <= BLANK_GAS[3:0];
      end
    end else if (clr_hit) begin
      for (int i = 0; i < DISP_DEPTH; i++) begin
        disp_a[i] <= (disp_mode == DISP_INDIV) ? BLANK_INDIV : {2'b00, BLANK_GAS[5:4]};
        disp_b[i] <= (disp_mode == DISP_INDIV) ? BLANK_INDIV : BLANK_GAS[3:0];
      end
    end else if (i_wr && (i_addr == ADDR_DATA)) begin
      if (ptr[0]) begin
        disp_b[pidx] <= i_wdata[3:0];
      end else begin
        disp_a[pidx] <= i_wdata[3:0];
      end
    end
  end

  // ----------------------------------------
  // display output ports
  // ----------------------------------------
  logic [GW-1:0] gas_cnt;
  logic [4:0] gidx;
  logic [4:0] gas_len;
  logic gas_clk;
  logic char_end;
  logic [3:0] indiv_a;
  logic [3:0] indiv_b;

  // character count from mode, not tied to scan
  always_comb begin
    case (disp_mode)
      DISP_GAS20: gas_len = GAS_LEN20;
      DISP_GAS18: gas_len = GAS_LEN18;
      default: gas_len = GAS_LEN16;
    endcase
  end
  assign char_end = (gas_cnt == GW'(GAS_CHAR_CYC - 1));
  assign gas_clk = gas_cnt[GW-1];
  assign indiv_a = disp_a[{1'b0, bank, line}];
  assign indiv_b = disp_b[{1'b0, bank, line}];

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      gas_cnt <= '0;
      gidx <= 5'h00;
    end else if (clr_hit || disp_mode == DISP_INDIV) begin
      gas_cnt <= '0;
      gidx <= 5'h00;
    end else begin
      gas_cnt <= gas_cnt + GW'(1);
      if (char_end) begin
        gidx <= (gidx >= gas_len - 5'h01) ? 5'h00 : gidx + 5'h01;
      end
    end
  end

  // refresh digit chosen by bank and line
  // reset and clock on port A upper bits
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_display_port_a <= 4'h0;
      o_display_port_b <= 4'h0;
    end else if (disp_mode == DISP_INDIV) begin
      o_display_port_a <= indiv_a;
      o_display_port_b <= indiv_b;
    end else begin
      o_display_port_a <= {gidx == 5'h00, gas_clk, disp_a[gidx][1:0]};
      o_display_port_b <= disp_b[gidx];
    end
  end

  // ----------------------------------------
  // return line drive
  // ----------------------------------------
  // hold low, pulse low, or float
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_return_lines_oe <= 8'h00;
    end else if (kbd_mode == KBD_SENSOR) begin
      o_return_lines_oe <= 8'hff;
    end else if (kbd_mode == KBD_SCAN && scan_cnt < SW'(RET_PULSE_CYC)) begin
      o_return_lines_oe <= 8'hff;
    end else begin
      o_return_lines_oe <= 8'h00;
    end
  end
  assign o_return_lines = 8'h00;

  // ----------------------------------------
  // key scanning and debounce
  // ----------------------------------------
  kbdsc_db_e db_state;
  logic [DW-1:0] deb_cnt;
  logic [7:0] key_state [NUM_LINES];
  logic [7:0] new_bits;
  logic [2:0] new_col;
  logic [2:0] pend_row;
  logic [2:0] pend_col;
  logic [1:0] pend_mod;
  logic scan_push;

  // lowest newly closed switch on this row
  always_comb begin
    new_bits = ret & ~key_state[line];
    new_col = 3'h0;
    for (int c = 7; c >= 0; c--) begin
      if (new_bits[c]) begin
        new_col = 3'(c);
      end
    end
  end

  // remember held keys so a second press is seen
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      for (int r = 0; r < NUM_LINES; r++) begin
        key_state[r] <= 8'h00;
      end
    end else if (line_end && kbd_mode == KBD_SCAN) begin
      key_state[line] <= ret;
    end
  end

  // bounce delay before confirming a key
  // shift captured only in scanned mode
  // control key joins the code when scanning
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      db_state <= DB_IDLE;
      deb_cnt <= '0;
      pend_row <= 3'h0;
      pend_col <= 3'h0;
      pend_mod <= 2'h0;
    end else if (clr_hit || kbd_mode != KBD_SCAN) begin
      db_state <= DB_IDLE;
      deb_cnt <= '0;
    end else begin
      case (db_state)
        DB_IDLE: begin
          if (line_end && (|new_bits)) begin
            pend_row <= line;
            pend_col <= new_col;
            pend_mod <= {ctrl, shift};
            deb_cnt <= '0;
            db_state <= DB_WAIT;
          end
        end
        DB_WAIT: begin
          deb_cnt <= deb_cnt + DW'(1);
          if (deb_cnt == DW'(P_DEB_CYC - 1)) begin
            db_state <= DB_CHECK;
          end
        end
        DB_CHECK: begin
          if (line_end && line == pend_row) begin
            db_state <= DB_IDLE;
          end
        end
        default: db_state <= DB_IDLE;
      endcase
    end
  end
  assign scan_push = (db_state == DB_CHECK) && line_end && (line == pend_row)
                     && ret[pend_col] && kbd_mode == KBD_SCAN && !clr_hit;

  // ----------------------------------------
  // character FIFO and sensor memory
  // ----------------------------------------
  logic [7:0] fifo [FIFO_DEPTH];
  logic [2:0] wp;
  logic [2:0] rp;
  logic [3:0] fifo_cnt;
  logic [2:0] srow;
  logic enc_push;
  logic push;
  logic push_ok;
  logic pop;
  logic [7:0] push_code;
  logic overrun;
  logic sens_chg;
  logic sens_write;

  // encoder strobe rising edge loads a character
  assign enc_push = kbd_mode == KBD_ENC && ctrl && !ctrl_q && !clr_hit;
  assign push = scan_push || enc_push;
  assign push_code = enc_push ? ret : {pend_mod, pend_row, pend_col};
  assign push_ok = push && (fifo_cnt != FIFO_FULL || pop);
  assign pop = fifo_rd && fifo_cnt != 4'h0 && kbd_mode != KBD_SENSOR;
  assign sens_write = kbd_mode == KBD_SENSOR && line_end && !clr_hit;

  // shared storage: queue or per-row sensor image
  always_ff @(posedge i_clk) begin
    if (sens_write) begin
      fifo[line] <= ret;
    end else if (push_ok) begin
      fifo[wp] <= push_code;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wp <= 3'h0;
      rp <= 3'h0;
      fifo_cnt <= 4'h0;
    end else if (clr_hit || kbd_mode == KBD_SENSOR) begin
      wp <= 3'h0;
      rp <= 3'h0;
      fifo_cnt <= 4'h0;
    end else begin
      wp <= push_ok ? wp + 3'h1 : wp;
      rp <= pop ? rp + 3'h1 : rp;
      fifo_cnt <= fifo_cnt + {3'h0, push_ok} - {3'h0, pop};
    end
  end

  // sticky flags; a new event beats the read that clears it
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      overrun <= 1'b0;
      sens_chg <= 1'b0;
      srow <= 3'h0;
    end else if (clr_hit) begin
      overrun <= 1'b0;
      sens_chg <= 1'b0;
    end else begin
      if (push && !push_ok) begin
        overrun <= 1'b1;
      end else if (i_rd && i_addr == ADDR_STATUS) begin
        overrun <= 1'b0;
      end
      if (sens_write && fifo[line] != ret) begin
        sens_chg <= 1'b1;
      end else if (fifo_rd && kbd_mode == KBD_SENSOR) begin
        sens_chg <= 1'b0;
      end
      if (i_wr && i_addr == ADDR_SROW) begin
        srow <= i_wdata[2:0];
      end
    end
  end

  assign o_int_n = !((fifo_cnt != 4'h0) || sens_chg);

  // ----------------------------------------
  // read port
  // ----------------------------------------
  // data valid only the cycle after a read
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        ADDR_MODE: o_rdata <= {4'h0, disp_mode, kbd_mode};
        ADDR_PTR: o_rdata <= {2'h0, ptr};
        ADDR_DATA: o_rdata <= {4'h0, ptr[0] ? disp_b[pidx] : disp_a[pidx]};
        ADDR_FIFO: o_rdata <= (kbd_mode == KBD_SENSOR) ? fifo[srow] : fifo[rp];
        ADDR_STATUS: o_rdata <= {2'h0, sens_chg, overrun, fifo_cnt};
        ADDR_SROW: o_rdata <= {5'h00, srow};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  chk_scan_onehot: assert property ($onehot(o_scan_lines))
    else $error("scan lines not one-hot");
  chk_bank_toggle: assert property (
    line_end && line == 3'h7 && !clr_hit |=> o_row_bank_select != $past(o_row_bank_select))
    else $error("bank select did not toggle");
  chk_indiv_refresh: assert property (
    disp_mode == DISP_INDIV ##1 disp_mode == DISP_INDIV |-> o_display_port_a == $past(indiv_a))
    else $error("port A not refreshed from scanned digit");
  chk_gas_pins: assert property (
    disp_mode != DISP_INDIV ##1 disp_mode != DISP_INDIV |-> o_display_port_a[2] == $past(gas_clk))
    else $error("gas clock not on port A bit 2");
  chk_gas_wrap: assert property (
    disp_mode == DISP_GAS18 && char_end && gidx == 5'h11 && !clr_hit |=> gidx == 5'h00)
    else $error("gas character count wrong");
  chk_ret_float: assert property (
    kbd_mode == KBD_ENC ##1 kbd_mode == KBD_ENC |-> o_return_lines_oe == 8'h00)
    else $error("return lines driven in encoded mode");
  chk_int_level: assert property ((fifo_cnt != 4'h0) |-> !o_int_n)
    else $error("interrupt missing with buffered character");
  chk_fifo_bound: assert property (fifo_cnt <= FIFO_FULL)
    else $error("fifo count beyond depth");
  chk_bounce_wait: assert property (
    db_state == DB_WAIT ##1 db_state == DB_CHECK |-> $past(deb_cnt) == DW'(P_DEB_CYC - 1))
    else $error("bounce delay length wrong");
  chk_clear_blank: assert property (
    clr_hit && disp_mode == DISP_INDIV |=> disp_a[0] == BLANK_INDIV && disp_b[0] == BLANK_INDIV)
    else $error("clear did not blank display");
  chk_rdata_idle: assert property (!i_rd |=> o_rdata == 8'h00)
    else $error("read data outside read reply");
endmodule : kbdsc_top

//--- core/kbdsc_pkg.sv
// kbdsc_pkg: shared constants of the keyboard and display scanner
package kbdsc_pkg;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int CLK_NS = 50;
  localparam int NUM_LINES = 8;
  localparam int SCAN_HZ = 180;
  localparam int SCAN_LINE_CYC = 1000000000 / (SCAN_HZ * NUM_LINES * CLK_NS);
  localparam int DEBOUNCE_MS = 11;
  localparam int DEBOUNCE_CYC = DEBOUNCE_MS * 1000000 / CLK_NS;
  localparam int RET_PULSE_CYC = 4;
  localparam int GAS_CHAR_CYC = 32;
  localparam int FIFO_DEPTH = 8;
  localparam int DISP_DEPTH = 20;
  localparam logic [3:0] FIFO_FULL = 4'h8;
  localparam logic [5:0] PTR_LAST = 6'h27;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [3:0] ADDR_MODE = 4'h0;
  localparam logic [3:0] ADDR_CLEAR = 4'h1;
  localparam logic [3:0] ADDR_PTR = 4'h2;
  localparam logic [3:0] ADDR_DATA = 4'h3;
  localparam logic [3:0] ADDR_FIFO = 4'h4;
  localparam logic [3:0] ADDR_STATUS = 4'h5;
  localparam logic [3:0] ADDR_SROW = 4'h6;
  localparam int STAT_OVR_BIT = 4;
  localparam int STAT_SENS_BIT = 5;
  localparam int MODE_DISP_LSB = 2;
  localparam int MODE_KBD_LSB = 0;
  // ----------------------------------------
  // modes, blanks, states
  // ----------------------------------------
  localparam logic [1:0] DISP_INDIV = 2'h0;
  localparam logic [1:0] DISP_GAS20 = 2'h1;
  localparam logic [1:0] DISP_GAS18 = 2'h2;
  localparam logic [1:0] DISP_GAS16 = 2'h3;
  localparam logic [1:0] KBD_SENSOR = 2'h0;
  localparam logic [1:0] KBD_SCAN = 2'h1;
  localparam logic [1:0] KBD_ENC = 2'h2;
  localparam logic [1:0] RST_DISP = DISP_GAS16;
  localparam logic [1:0] RST_KBD = KBD_SCAN;
  localparam logic [4:0] GAS_LEN20 = 5'h14;
  localparam logic [4:0] GAS_LEN18 = 5'h12;
  localparam logic [4:0] GAS_LEN16 = 5'h10;
  localparam logic [3:0] BLANK_INDIV = 4'hf;
  localparam logic [5:0] BLANK_GAS = 6'h20;
  typedef enum logic [2:0] {
    DB_IDLE = 3'b001,
    DB_WAIT = 3'b010,
    DB_CHECK = 3'b100
  } kbdsc_db_e;
endpackage : kbdsc_pkg

//--- verification/kbdsc_keypad_model.sv
// kbdsc_keypad_model: switch matrix and encoder facing the scan and return lines
`timescale 1ns/10ps
module kbdsc_keypad_model (
  input wire logic [7:0] i_scan_lines,
  input wire logic [63:0] i_keys,
  input wire logic i_enc_en,
  input wire logic [7:0] i_enc_code,
  output logic [7:0] o_return_lines
);
  // ----------------------------------------
  // return line levels
  // ----------------------------------------
  // a closed switch on the sourced row pulls its return line high; the device
  // only pulls lines low weakly, so the switch wins, and an open line reads low
  always_comb begin
    o_return_lines = 8'h00;
    for (int r = 0; r < 8; r++) begin
      if (i_scan_lines[r]) begin
        o_return_lines = o_return_lines | i_keys[r*8 +: 8];
      end
    end
    if (i_enc_en) begin
      o_return_lines = i_enc_code; // encoder output replaces the matrix
    end
  end
endmodule : kbdsc_keypad_model

//--- verification/kbdsc_top_tb.sv
// kbdsc_top_tb: self-checking bench for the keyboard and display scanner
`timescale 1ns/10ps
module kbdsc_top_tb;
  import kbdsc_pkg::*;
  localparam int SCAN = 16;
  localparam int DEB = 8;
  logic i_clk, i_rst_n, i_wr, i_rd, i_shift_key, i_ctrl_strobe;
  logic o_row_bank_select, o_int_n, enc_en;
  logic [3:0] i_addr, o_display_port_a, o_display_port_b;
  logic [7:0] i_wdata, o_rdata, o_scan_lines, i_return_lines;
  logic [7:0] o_return_lines, o_return_lines_oe, enc_code, rd_val;
  logic [63:0] keys;
  logic [7:0] gm [3] = '{8'h05, 8'h09, 8'h0d};
  int gl [3] = '{20, 18, 16};
  int err_count, checks_done, cyc, rst_hits, ck, bad;
  kbdsc_top #(.P_SCAN_CYC(SCAN), .P_DEB_CYC(DEB)) i_dut (
    .i_clk(i_clk), .i_rst_n(i_rst_n), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_scan_lines(o_scan_lines),
    .o_row_bank_select(o_row_bank_select), .o_display_port_a(o_display_port_a),
    .o_display_port_b(o_display_port_b), .i_return_lines(i_return_lines),
    .o_return_lines(o_return_lines), .o_return_lines_oe(o_return_lines_oe),
    .i_shift_key(i_shift_key), .i_ctrl_strobe(i_ctrl_strobe), .o_int_n(o_int_n));
  kbdsc_keypad_model i_pad (.i_scan_lines(o_scan_lines), .i_keys(keys),
    .i_enc_en(enc_en), .i_enc_code(enc_code), .o_return_lines(i_return_lines));

  // ----------------------------------------
  // clock, timeout and reporting
  // ----------------------------------------
  // one clock paces both sides
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  // generous ceiling: the whole sequence needs well under ten thousand cycles
  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      finish_test();
    end
  end

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic finish_test();
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  // ----------------------------------------
  // register port and stimulus tasks
  // ----------------------------------------
  // strobe marks addressed cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_addr <= a;
    i_wdata <= d;
    i_wr <= 1'b1;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe, so sample it mid-cycle
  task automatic rd(input logic [3:0] a);
    @(posedge i_clk);
    i_addr <= a;
    i_rd <= 1'b1;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    rd_val = o_rdata;
  endtask : rd

  task automatic wait_int();
    int n;
    n = 0;
    while (o_int_n !== 1'b0 && n < 1000) begin
      @(negedge i_clk);
      n++;
    end
    check("int_low", {7'h0, o_int_n}, 8'h00);
  endtask : wait_int

  task automatic strobe(input logic [7:0] c);
    @(posedge i_clk);
    enc_code <= c;
    @(posedge i_clk);
    i_ctrl_strobe <= 1'b1;
    repeat (3) @(posedge i_clk);
    i_ctrl_strobe <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask : strobe

  // follows n line changes; the first interval starts mid-line, so it is not timed
  task automatic walk(input int n, input bit ports, input bit oe);
    logic [7:0] prev;
    logic bank, eb;
    int len, hi, line;
    for (int k = 0; k < n; k++) begin
      prev = o_scan_lines;
      bank = o_row_bank_select;
      len = 0;
      hi = 0;
      while (o_scan_lines === prev && len < 40) begin
        @(negedge i_clk);
        len++;
        hi += (o_return_lines_oe === 8'hff);
      end
      eb = bank ^ (prev == 8'h80);
      check("scan", o_scan_lines, {prev[6:0], prev[7]});
      check("bank", {7'h0, o_row_bank_select}, {7'h0, eb});
      if (k > 0 && !ports) begin
        check("line_len", len[7:0], SCAN[7:0]);
      end
      if (k > 0 && oe) begin
        check("ret_pulse", hi[7:0], 8'h04);
      end
      if (ports) begin
        @(negedge i_clk);
        line = $clog2(o_scan_lines);
        check("port_a", {4'h0, o_display_port_a}, {4'h0, eb, line[2:0]});
        check("port_b", {4'h0, o_display_port_b}, {4'h0, eb, line[2:0]} ^ 8'h05);
      end
    end
  endtask : walk

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    i_rst_n = 1'b0;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_addr = 4'h0;
    i_wdata = 8'h00;
    i_shift_key = 1'b0;
    i_ctrl_strobe = 1'b0;
    keys = 64'h0;
    enc_en = 1'b0;
    enc_code = 8'h00;
    repeat (10) @(posedge i_clk);
    check("scan_rst", o_scan_lines, 8'h01);
    check("int_rst", {7'h0, o_int_n}, 8'h01);
    i_rst_n <= 1'b1;
    rd(ADDR_MODE);
    check("mode_rst", rd_val, 8'h0d);
    @(negedge i_clk);
    check("rdata_idle", o_rdata, 8'h00);
    walk(17, 1'b0, 1'b1);
    // every display and keyboard mode code reads back as written
    for (int d = 0; d < 4; d++) begin
      for (int k = 0; k < 3; k++) begin
        wr(ADDR_MODE, 8'(4 * d + k));
        rd(ADDR_MODE);
        check("mode", rd_val, 8'(4 * d + k));
      end
    end
    wr(4'hf, 8'h0a);
    rd(4'hf);
    check("unmapped", rd_val, 8'h00);
    // individual display: blanks, then digit i in A and i^5 in B
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CLEAR, 8'h00);
    repeat (SCAN + 2) @(negedge i_clk);
    check("blank_a", {4'h0, o_display_port_a}, 8'h0f);
    check("blank_b", {4'h0, o_display_port_b}, 8'h0f);
    wr(ADDR_PTR, 8'h00);
    for (int i = 0; i < 16; i++) begin
      wr(ADDR_DATA, 8'(i));
      wr(ADDR_DATA, 8'(i ^ 5));
    end
    wr(ADDR_PTR, 8'h03);
    rd(ADDR_DATA);
    check("data_b1", rd_val, 8'h04);
    rd(ADDR_DATA);
    check("data_a2", rd_val, 8'h02);
    walk(17, 1'b1, 1'b0);
    // scanned keys with shift, a rollover key, then a control key
    @(posedge i_clk);
    i_shift_key <= 1'b1;
    keys[2*8+5] <= 1'b1;
    wait_int();
    rd(ADDR_STATUS);
    check("count1", rd_val, 8'h01);
    rd(ADDR_FIFO);
    check("key_shift", rd_val, 8'h55);
    check("int_clear", {7'h0, o_int_n}, 8'h01);
    @(posedge i_clk);
    keys[3*8+6] <= 1'b1;
    wait_int();
    rd(ADDR_FIFO);
    check("rollover", rd_val, 8'h5e);
    @(posedge i_clk);
    keys <= 64'h0;
    i_shift_key <= 1'b0;
    i_ctrl_strobe <= 1'b1;
    repeat (2 * 8 * SCAN) @(posedge i_clk);
    keys[7*8] <= 1'b1;
    wait_int();
    rd(ADDR_FIFO);
    check("key_ctrl", rd_val, 8'hb8);
    // encoded keyboard: overfill the buffer, then drain it in order
    @(posedge i_clk);
    keys <= 64'h0;
    i_ctrl_strobe <= 1'b0;
    i_shift_key <= 1'b1;
    enc_en <= 1'b1;
    wr(ADDR_MODE, 8'h02);
    repeat (4) @(negedge i_clk);
    check("ret_float", o_return_lines_oe, 8'h00);
    check("ret_drive", o_return_lines, 8'h00);
    for (int i = 0; i < 9; i++) begin
      strobe(8'(8'h30 + i));
    end
    rd(ADDR_STATUS);
    check("full_ovr", rd_val, 8'h18);
    rd(ADDR_STATUS);
    check("ovr_clear", rd_val, 8'h08);
    for (int i = 0; i < 8; i++) begin
      rd(ADDR_FIFO);
      check("fifo_order", rd_val, 8'(8'h30 + i));
    end
    check("int_empty", {7'h0, o_int_n}, 8'h01);
    // sensor matrix: one closed sensor in row 3, column 1
    @(posedge i_clk);
    enc_en <= 1'b0;
    i_shift_key <= 1'b0;
    wr(ADDR_MODE, 8'h00);
    @(posedge i_clk);
    keys[3*8+1] <= 1'b1;
    repeat (20 * SCAN) @(negedge i_clk);
    check("ret_low", o_return_lines_oe, 8'hff);
    check("int_sens", {7'h0, o_int_n}, 8'h00);
    wr(ADDR_SROW, 8'h03);
    rd(ADDR_FIFO);
    check("sens_row", rd_val, 8'h02);
    check("int_sens_clr", {7'h0, o_int_n}, 8'h01);
    // gas discharge: two whole frames per length, blanks everywhere
    @(posedge i_clk);
    keys <= 64'h0;
    for (int g = 0; g < 3; g++) begin
      wr(ADDR_MODE, gm[g]);
      wr(ADDR_CLEAR, 8'h00);
      repeat (4) @(negedge i_clk);
      rst_hits = 0;
      ck = 0;
      bad = 0;
      repeat (gl[g] * 64) begin
        @(negedge i_clk);
        rst_hits += (o_display_port_a[3] === 1'b1);
        ck += (o_display_port_a[2] === 1'b1);
        bad += (o_display_port_a[1:0] !== 2'h2 || o_display_port_b !== 4'h0);
      end
      check("gas_reset", rst_hits[7:0], 8'h40);
      check("gas_clock", 8'(ck / gl[g]), 8'h20);
      check("gas_blank", bad[7:0], 8'h00);
    end
    finish_test();
  end
endmodule : kbdsc_top_tb
